/* rtl/hdlsf_pkg.sv */
// ==========================================================================
// shared constants for the data link event status bank
package hdlsf_pkg;

  // ========================================================================
  // register indices as printed; byte address is four times the index
  localparam logic [7:0] HDLSF_IDX_STATUS = 8'h06;
  localparam logic [7:0] HDLSF_IDX_ENABLE = 8'h07;
  localparam int         HDLSF_ADDR_LSB   = 2;

  // ========================================================================
  // bit positions within the status and enable registers
  localparam int HDLSF_BIT_KIND      = 7;
  localparam int HDLSF_BIT_TX_BEGIN  = 6;
  localparam int HDLSF_BIT_RX_BEGIN  = 5;
  localparam int HDLSF_BIT_TX_FINISH = 4;
  localparam int HDLSF_BIT_RX_FINISH = 3;
  localparam int HDLSF_BIT_FCS_FAIL  = 2;
  localparam int HDLSF_BIT_ABORT     = 1;
  localparam int HDLSF_BIT_FLAG_OCT  = 0;
  localparam int HDLSF_NUM_EVENTS    = 7;

  // ========================================================================
  // reset values
  localparam logic [6:0] HDLSF_RST_FLAGS  = 7'h00;
  localparam logic [6:0] HDLSF_RST_ENABLE = 7'h00;
  localparam logic       HDLSF_RST_KIND   = 1'b0;

  // ========================================================================
  // axi responses
  localparam logic [1:0] HDLSF_RESP_OKAY   = 2'b00;
  localparam logic [1:0] HDLSF_RESP_SLVERR = 2'b10;

endpackage

/* rtl/hdlsf_top.sv */
`timescale 1ns/10ps

module hdlsf_top
  import hdlsf_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  // clock and reset
  input  wire logic              CLK_SYS_I,
  input  wire logic              NRST_I,
  // event strobes from the hdlc controllers, one cycle each
  input  wire logic              TX_BEGIN_I,
  input  wire logic              RX_BEGIN_I,
  input  wire logic              TX_FINISH_I,
  input  wire logic              RX_FINISH_I,
  input  wire logic              RX_BUF_FULL_I,
  input  wire logic              FCS_FAIL_I,
  input  wire logic              ABORT_SEEN_I,
  input  wire logic              FLAG_OCTET_I,
  // received message kind, taken when its strobe is high
  input  wire logic              MSG_KIND_I,
  input  wire logic              MSG_KIND_VLD_I,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
  input  wire logic [2:0]        S_AXI_AWPROT_I,
  input  wire logic              S_AXI_AWVALID_I,
  output logic                   S_AXI_AWREADY_O,
  // axi4-lite write data
  input  wire logic [31:0]       S_AXI_WDATA_I,
  input  wire logic [3:0]        S_AXI_WSTRB_I,
  input  wire logic              S_AXI_WVALID_I,
  output logic                   S_AXI_WREADY_O,
  // axi4-lite write response
  output logic [1:0]             S_AXI_BRESP_O,
  output logic                   S_AXI_BVALID_O,
  input  wire logic              S_AXI_BREADY_I,
  // axi4-lite read address
  input  wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
  input  wire logic [2:0]        S_AXI_ARPROT_I,
  input  wire logic              S_AXI_ARVALID_I,
  output logic                   S_AXI_ARREADY_O,
  // axi4-lite read data
  output logic [31:0]            S_AXI_RDATA_O,
  output logic [1:0]             S_AXI_RRESP_O,
  output logic                   S_AXI_RVALID_O,
  input  wire logic              S_AXI_RREADY_I,
  // interrupt, level
  output logic                   IRQ_O
);

  // ========================================================================
  // elaboration checks
  if (ADDR_W < 5)
  begin : g_chk
    $error("ADDR_W too small to reach the register indices");
  end

  if (ADDR_W > 64)
  begin : g_chk_wide
    $error("ADDR_W wider than any axi address");
  end

  // the flag logic is built for exactly seven events under the kind bit
  if (HDLSF_NUM_EVENTS != 7)
  begin : g_chk_events
    $error("event count must be seven");
  end

  if (HDLSF_BIT_KIND != HDLSF_NUM_EVENTS)
  begin : g_chk_kind
    $error("kind bit must sit just above the event flags");
  end

  // one 32-bit word per register, so the index is the address over four
  if (HDLSF_ADDR_LSB != 2)
  begin : g_chk_lsb
    $error("registers must be aligned 32-bit words");
  end

  if (HDLSF_IDX_STATUS == HDLSF_IDX_ENABLE)
  begin : g_chk_map
    $error("status and enable must not share an index");
  end

  // ========================================================================
  // whole module state
  // bus holding fields first, then the register contents
  typedef struct packed {
    logic [ADDR_W-1:0] aw_addr;
    logic              aw_got;
    logic [7:0]        w_data;
    logic              w_lane0;
    logic              w_got;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic [6:0]        flags;
    logic              kind;
    logic [6:0]        enable;
    logic              irq;
  } hdlsf_state_t;

  hdlsf_state_t st_r;
  hdlsf_state_t st_nxt;

  // ========================================================================
  // register map, one aligned word each, byte lane 0 only
  //   status 0x18: kind bit on top, seven sticky event flags below
  //   enable 0x1C: interrupt mask in the same layout, top bit reads zero
  //   elsewhere  : slave error, reads return zero, writes change nothing
  // a read clears every flag it returned; an event in the read cycle is
  // kept for the next read, so no event slips between two reads
  // writing ones to status also clears, for drivers that avoid read
  // side effects

  // ========================================================================
  // address decode helper, shared by both channels
  // 01 status, 10 enable, 00 anything else; low address bits ignored
  function automatic logic [1:0] hdlsf_decode(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] idx;
    idx = a >> HDLSF_ADDR_LSB;
    hdlsf_decode = 2'b00;
    if (idx == ADDR_W'(HDLSF_IDX_STATUS))
      hdlsf_decode = 2'b01;
    else if (idx == ADDR_W'(HDLSF_IDX_ENABLE))
      hdlsf_decode = 2'b10;
  endfunction

  logic [6:0] events;
  logic       aw_hs;
  logic       w_hs;
  logic       ar_hs;
  logic [1:0] rd_sel;
  logic [1:0] wr_sel;

  // event vector in register bit order; each strobe high for one cycle
  // sets its flag at the closing edge, a strobe held high keeps it set,
  // and the buffer-full strobe shares the receive-end flag
  always_comb
  begin
    events                      = '0;
    events[HDLSF_BIT_TX_BEGIN]  = TX_BEGIN_I;
    events[HDLSF_BIT_RX_BEGIN]  = RX_BEGIN_I;
    events[HDLSF_BIT_TX_FINISH] = TX_FINISH_I;
    events[HDLSF_BIT_RX_FINISH] = RX_FINISH_I | RX_BUF_FULL_I;
    events[HDLSF_BIT_FCS_FAIL]  = FCS_FAIL_I;
    events[HDLSF_BIT_ABORT]     = ABORT_SEEN_I;
    events[HDLSF_BIT_FLAG_OCT]  = FLAG_OCTET_I;
  end

  // bus timing: address and data taken in either order; the word lands
  // one edge after both are held and the response rises with it; a read
  // answers one edge after its address; reads never wait on writes
  // ready terms; one outstanding write and one read at a time
  assign S_AXI_AWREADY_O = !st_r.aw_got && !st_r.bvalid;
  assign S_AXI_WREADY_O  = !st_r.w_got && !st_r.bvalid;
  assign S_AXI_ARREADY_O = !st_r.rvalid;
  assign aw_hs           = S_AXI_AWVALID_I && S_AXI_AWREADY_O;
  assign w_hs            = S_AXI_WVALID_I && S_AXI_WREADY_O;
  assign ar_hs           = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
  assign rd_sel          = hdlsf_decode(S_AXI_ARADDR_I);
  assign wr_sel          = hdlsf_decode(st_r.aw_addr);

  // ========================================================================
  // sticky flag cells
  logic [6:0] rd_clr;
  logic [6:0] wr_clr;
  logic [6:0] flag_nxt;

  // clear sources: a status read clears all, a status write clears ones
  always_comb
  begin
    rd_clr = '0;
    wr_clr = '0;
    if (ar_hs && rd_sel == 2'b01)
      rd_clr = '1;
    // a write with lane 0 off clears nothing, as on the enable path
    if (st_r.aw_got && st_r.w_got && wr_sel == 2'b01 && st_r.w_lane0)
      wr_clr = st_r.w_data[6:0];
  end

  // one cell per event; the set term wins so no event is lost to a clear
  for (genvar g = 0; g < HDLSF_NUM_EVENTS; g++)
  begin : g_flag
    assign flag_nxt[g] = events[g]
                       | (st_r.flags[g] & ~(rd_clr[g] | wr_clr[g]));
  end

  // ========================================================================
  // next state
  always_comb
  begin
    logic [7:0] status_view;
    status_view = {st_r.kind, st_r.flags};
    st_nxt      = st_r;

    // capture address and data independently, in either order
    // limitation: lanes 1-3 of wstrb and both prot fields are ignored
    if (aw_hs)
    begin
      st_nxt.aw_addr = S_AXI_AWADDR_I;
      st_nxt.aw_got  = 1'b1;
    end
    if (w_hs)
    begin
      st_nxt.w_data  = S_AXI_WDATA_I[7:0];
      st_nxt.w_lane0 = S_AXI_WSTRB_I[0];
      st_nxt.w_got   = 1'b1;
    end

    // perform write once both halves are held
    if (st_r.aw_got && st_r.w_got)
    begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got  = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = HDLSF_RESP_OKAY;
      if (wr_sel == 2'b10)
      begin
        if (st_r.w_lane0)
          st_nxt.enable = st_r.w_data[6:0];
      end
      else if (wr_sel == 2'b00)
        st_nxt.bresp = HDLSF_RESP_SLVERR;
      // status writes clear through wr_clr; the kind bit ignores writes
    end
    if (st_r.bvalid && S_AXI_BREADY_I)
      st_nxt.bvalid = 1'b0;

    // read path; a status read returns flags, rd_clr then clears them
    if (ar_hs)
    begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp  = HDLSF_RESP_OKAY;
      st_nxt.rdata  = '0;
      if (rd_sel == 2'b01)
      begin
        st_nxt.rdata = {24'h00_0000, status_view};
      end
      else if (rd_sel == 2'b10)
        st_nxt.rdata = {25'h000_0000, st_r.enable};
      else
        st_nxt.rresp = HDLSF_RESP_SLVERR;
    end
    else if (st_r.rvalid && S_AXI_RREADY_I)
      st_nxt.rvalid = 1'b0;

    // sticky cells computed above, set winning over clear
    st_nxt.flags = flag_nxt;

    // message kind follows the receiver, never software
    if (MSG_KIND_VLD_I)
      st_nxt.kind = MSG_KIND_I;

    // level interrupt from unmasked sticky flags; taken from the next
    // values so it rises with the flag and drops with the clearing read
    st_nxt.irq = |(st_nxt.flags & st_nxt.enable);
  end

  // ========================================================================
  // state register, synchronous active-low reset
  // the whole struct is cleared first, then the reset constants are laid
  // over it so a change of those constants takes effect here
  always_ff @(posedge CLK_SYS_I)
  begin
    if (!NRST_I)
    begin
      st_r        <= '0;
      st_r.flags  <= HDLSF_RST_FLAGS;
      st_r.kind   <= HDLSF_RST_KIND;
      st_r.enable <= HDLSF_RST_ENABLE;
    end
    else
      st_r <= st_nxt;
  end

  // ========================================================================
  // registered outputs
  // every data output comes straight from the state register; only the
  // three ready terms reach the bus combinationally
  assign S_AXI_BVALID_O = st_r.bvalid;
  assign S_AXI_BRESP_O  = st_r.bresp;
  assign S_AXI_RVALID_O = st_r.rvalid;
  assign S_AXI_RDATA_O  = st_r.rdata;
  assign S_AXI_RRESP_O  = st_r.rresp;
  assign IRQ_O          = st_r.irq;

endmodule

/* test/hdlsf_assertions.sv */
`timescale 1ns/10ps
// ===========================================
// bus and flag checks on the top-level ports
module hdlsf_sva
  import hdlsf_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  // clock, reset, events
  input wire logic              CLK_SYS_I,
  input wire logic              NRST_I,
  input wire logic              TX_BEGIN_I,
  input wire logic              FCS_FAIL_I,
  // register bus
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
  input wire logic              S_AXI_ARVALID_I,
  input wire logic              S_AXI_ARREADY_O,
  input wire logic [31:0]       S_AXI_RDATA_O,
  input wire logic              S_AXI_RVALID_O,
  input wire logic              S_AXI_RREADY_I,
  input wire logic              S_AXI_AWREADY_O,
  input wire logic              S_AXI_BVALID_O,
  input wire logic              IRQ_O
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!NRST_I);
  // status read taken at this edge
  sequence rd_st;
    S_AXI_ARVALID_I && S_AXI_ARREADY_O && S_AXI_ARADDR_I ==
      ADDR_W'(HDLSF_IDX_STATUS) << HDLSF_ADDR_LSB;
  endsequence
  AST_RVAL: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O
    |=> S_AXI_RVALID_O) else $error("read answer missing");
  AST_RHOLD: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I
    |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O))
    else $error("read data not held");
  AST_TXB: assert property (TX_BEGIN_I ##[1:3] rd_st
    |=> S_AXI_RDATA_O[6]) else $error("tx begin flag lost");
  AST_FCS: assert property (FCS_FAIL_I ##[1:3] rd_st
    |=> S_AXI_RDATA_O[2]) else $error("fcs flag lost");
  AST_CLR: assert property ((!TX_BEGIN_I throughout
    (rd_st ##[1:4] rd_st)) |=> !S_AXI_RDATA_O[6])
    else $error("flag not cleared by read");
  AST_BV: assert property (S_AXI_BVALID_O |-> !S_AXI_AWREADY_O)
    else $error("write taken during response");
  AST_ARRDY: assert property (S_AXI_RVALID_O |-> !S_AXI_ARREADY_O)
    else $error("read taken during answer");
  AST_RST: assert property ($rose(NRST_I) |-> !IRQ_O
    && !S_AXI_RVALID_O && !S_AXI_BVALID_O) else $error("reset state");
endmodule

bind hdlsf_top hdlsf_sva #(.ADDR_W(ADDR_W)) u_sva (.*);

/* test/tb.sv */
`timescale 1ns/10ps
// ===========================================
// status bank bench: bus tasks, flag tests
module tb
  import hdlsf_pkg::*;
;
  logic        CLK_SYS_I, NRST_I, MSG_KIND_I, IRQ_O;
  logic [8:0]  evt;
  wire         TX_BEGIN_I, RX_BEGIN_I, TX_FINISH_I, RX_FINISH_I;
  wire         RX_BUF_FULL_I, FCS_FAIL_I, ABORT_SEEN_I, FLAG_OCTET_I;
  wire         MSG_KIND_VLD_I;
  logic [7:0]  S_AXI_AWADDR_I, S_AXI_ARADDR_I;
  logic [31:0] S_AXI_WDATA_I, S_AXI_RDATA_O, rdat;
  logic [2:0]  S_AXI_AWPROT_I, S_AXI_ARPROT_I;
  logic [1:0]  S_AXI_BRESP_O, S_AXI_RRESP_O, brsp, rrsp;
  logic [3:0]  S_AXI_WSTRB_I;
  logic        S_AXI_AWVALID_I, S_AXI_WVALID_I, S_AXI_BREADY_I;
  logic        S_AXI_ARVALID_I, S_AXI_RREADY_I, S_AXI_AWREADY_O;
  logic        S_AXI_WREADY_O, S_AXI_BVALID_O, S_AXI_ARREADY_O;
  logic        S_AXI_RVALID_O;
  int          err_count, compares;
  localparam logic [7:0] ST = HDLSF_IDX_STATUS << HDLSF_ADDR_LSB;
  localparam logic [7:0] EN = HDLSF_IDX_ENABLE << HDLSF_ADDR_LSB;

  // event bits share the status layout; 7 is kind strobe, 8 buffer full
  assign {RX_BUF_FULL_I, MSG_KIND_VLD_I, TX_BEGIN_I, RX_BEGIN_I,
    TX_FINISH_I, RX_FINISH_I, FCS_FAIL_I, ABORT_SEEN_I, FLAG_OCTET_I} = evt;
  hdlsf_top i_dut (.*);

  // 50 MHz clock
  initial
  begin
    CLK_SYS_I = 1'b0;
    forever #10 CLK_SYS_I = ~CLK_SYS_I;
  end

  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      err_count++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask

  // write: offer address and data together, release each when taken
  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic aw_pend;
    logic w_pend;
    aw_pend = 1'b1;
    w_pend  = 1'b1;
    @(posedge CLK_SYS_I);
    S_AXI_AWADDR_I <= a;
    S_AXI_WDATA_I <= d;
    S_AXI_AWVALID_I <= 1'b1;
    S_AXI_WVALID_I <= 1'b1;
    S_AXI_BREADY_I <= 1'b1;
    // pending bits follow the sampled readies, not the stale valids
    do
    begin
      @(posedge CLK_SYS_I);
      if (aw_pend && S_AXI_AWREADY_O)
      begin
        aw_pend = 1'b0;
        S_AXI_AWVALID_I <= 1'b0;
      end
      if (w_pend && S_AXI_WREADY_O)
      begin
        w_pend = 1'b0;
        S_AXI_WVALID_I <= 1'b0;
      end
    end while (aw_pend || w_pend);
    while (!S_AXI_BVALID_O)
      @(posedge CLK_SYS_I);
    brsp = S_AXI_BRESP_O;
    S_AXI_BREADY_I <= 1'b0;
  endtask

  // read; m pulses events in the address cycle, rready comes late
  task automatic rd(logic [7:0] a, logic [8:0] m = 9'h000);
    @(posedge CLK_SYS_I);
    S_AXI_ARADDR_I <= a;
    S_AXI_ARVALID_I <= 1'b1;
    evt <= m;
    do @(posedge CLK_SYS_I); while (!S_AXI_ARREADY_O);
    S_AXI_ARVALID_I <= 1'b0;
    evt <= 9'h000;
    @(posedge CLK_SYS_I);
    S_AXI_RREADY_I <= 1'b1;
    do @(posedge CLK_SYS_I); while (!S_AXI_RVALID_O);
    rdat = S_AXI_RDATA_O;
    rrsp = S_AXI_RRESP_O;
    S_AXI_RREADY_I <= 1'b0;
  endtask

  task automatic ev(logic [8:0] m);
    @(posedge CLK_SYS_I);
    evt <= m;
    @(posedge CLK_SYS_I);
    evt <= 9'h000;
  endtask

  task automatic rs(string n, logic [7:0] e);
    rd(ST);
    chk(n, rdat, {24'h00_0000, e});
  endtask

  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // hang guard, far beyond the few hundred cycles the tests use
  initial
  begin
    repeat (5000) @(posedge CLK_SYS_I);
    err_count++;
    end_sim();
  end

  // ===========================================
  // test sequence
  initial
  begin
    {NRST_I, MSG_KIND_I, evt, S_AXI_AWPROT_I, S_AXI_ARPROT_I} = '0;
    {S_AXI_AWVALID_I, S_AXI_WVALID_I, S_AXI_BREADY_I} = '0;
    {S_AXI_ARVALID_I, S_AXI_RREADY_I, S_AXI_AWADDR_I} = '0;
    {S_AXI_ARADDR_I, S_AXI_WDATA_I} = '0;
    S_AXI_WSTRB_I = 4'h1;
    repeat (12) @(posedge CLK_SYS_I);
    NRST_I <= 1'b1;
    rs("status", 8'h00);
    rd(EN);
    chk("enable", rdat, 32'h0000_0000);
    $display("reset test done");
    for (int i = 0; i < 9; i++)
    begin
      ev(9'h001 << i);
      rs("event", i == 8 ? 8'h08 : 8'h7F & (8'h01 << i));
      rs("cleared", 8'h00);
    end
    MSG_KIND_I <= 1'b1;
    ev(9'h080);
    rs("kind", 8'h80);
    wr(ST, 32'h0000_00FF);
    rs("kind kept", 8'h80);
    MSG_KIND_I <= 1'b0;
    ev(9'h080);
    rs("kind zero", 8'h00);
    ev(9'h040);
    rs("tx start", 8'h40);
    ev(9'h010);
    rs("tx end", 8'h10);
    ev(9'h009);
    rs("whole msg", 8'h09);
    $display("event test done");
    wr(EN, 32'h0000_003F);
    rd(EN);
    chk("enable", rdat, 32'h0000_003F);
    S_AXI_WSTRB_I <= 4'h0;
    wr(EN, 32'h0000_0000);
    S_AXI_WSTRB_I <= 4'h1;
    rd(EN);
    chk("strobe off", rdat, 32'h0000_003F);
    ev(9'h040);
    @(negedge CLK_SYS_I);
    chk("irq masked", IRQ_O, 1'b0);
    ev(9'h020);
    @(negedge CLK_SYS_I);
    chk("irq", IRQ_O, 1'b1);
    rs("both", 8'h60);
    chk("irq off", IRQ_O, 1'b0);
    ev(9'h004);
    rd(ST, 9'h004);
    chk("snap", rdat, 32'h0000_0004);
    rs("set wins", 8'h04);
    ev(9'h002);
    wr(ST, 32'h0000_0002);
    rs("write clear", 8'h00);
    rd(8'h00);
    chk("bad read", {rrsp, rdat[29:0]}, 32'h8000_0000);
    wr(8'h04, 32'h0000_0001);
    chk("bad write", brsp, HDLSF_RESP_SLVERR);
    $display("irq and bus test done");
    ev(9'h001);
    NRST_I <= 1'b0;
    repeat (2) @(posedge CLK_SYS_I);
    NRST_I <= 1'b1;
    rs("after reset", 8'h00);
    rd(EN);
    chk("enable reset", rdat, 32'h0000_0000);
    $display("second reset test done");
    end_sim();
  end
endmodule
